// File: hdl/dmcp_port.sv
// Dual-mode control port: I2C and SPI register access, standalone straps
`timescale 1ns/100ps
`default_nettype none
`include "dmcp_cfg.svh"

module dmcp_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic control_serial_clock,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic standalone_select_pin,
  input wire logic serial_output_two,
  output logic standalone_active,
  output logic boost_power_down,
  output logic mic_bias_power_down,
  output logic diagnostics_power_down,
  output logic port_format_tdm,
  output logic tdm_eight_slot,
  output logic port_is_slave,
  output logic mclk_ratio_384,
  output logic sample_rate_96k,
  output logic spi_mode_active,
  output logic reg_update_pulse
);

  // ----------------------------------------
  // Pin roles
  // ----------------------------------------
  localparam logic [8*`DMCP_REG_COUNT-1:0] REG_RESET = `DMCP_REG_RESET;

  logic spi_latch_select;
  logic control_data_in;
  logic spi_clr;

  assign spi_latch_select = address_strap_low;
  assign control_data_in = address_strap_high;
  assign spi_clr = rst | spi_latch_select;

  // ----------------------------------------
  // Standalone straps, system domain
  // ----------------------------------------
  dmcp_sa_if sa_bus ();

  dmcp_standalone u_standalone (
    .clock(clock),
    .rst(rst),
    .standalone_select_pin(standalone_select_pin),
    .address_strap_low(address_strap_low),
    .address_strap_high(address_strap_high),
    .sda_level(sda_in),
    .scl_level(control_serial_clock),
    .serial_output_two(serial_output_two),
    .sa(sa_bus.src)
  );

  assign standalone_active = sa_bus.active;
  assign boost_power_down = sa_bus.active;
  assign mic_bias_power_down = sa_bus.active;
  assign diagnostics_power_down = sa_bus.active;
  assign port_format_tdm = sa_bus.tdm;
  assign tdm_eight_slot = sa_bus.eight_slot;
  assign port_is_slave = sa_bus.port_slave;
  assign mclk_ratio_384 = sa_bus.mclk_384;
  assign sample_rate_96k = sa_bus.rate_96k;

  // ----------------------------------------
  // Start and stop capture on data edges
  // ----------------------------------------
  logic start_tgl_q;
  logic start_tgl_d;
  logic stop_tgl_q;
  logic stop_tgl_d;

  always_comb begin
    start_tgl_d = control_serial_clock ? ~start_tgl_q : start_tgl_q;
    stop_tgl_d = control_serial_clock ? ~stop_tgl_q : stop_tgl_q;
  end

  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0;
    end else begin
      start_tgl_q <= start_tgl_d;
    end
  end

  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tgl_q <= 1'b0;
    end else begin
      stop_tgl_q <= stop_tgl_d;
    end
  end

  // ----------------------------------------
  // Link control: strap sync, event seen, SPI entry
  // ----------------------------------------
  logic [2:0] lk_meta_q;
  logic [2:0] lk_meta_d;
  logic [2:0] lk_sync_q;
  logic [2:0] lk_sync_d;
  logic start_seen_q;
  logic start_seen_d;
  logic stop_seen_q;
  logic stop_seen_d;
  logic [1:0] entry_q;
  logic [1:0] entry_d;
  logic wr_tgl_q;
  logic wr_tgl_d;
  logic start_evt;
  logic stop_evt;
  logic spi_mode;
  logic i2c_en;
  logic s_in_txn_q;
  logic reg_we;

  assign start_evt = start_tgl_q ^ start_seen_q;
  assign stop_evt = stop_tgl_q ^ stop_seen_q;
  assign spi_mode = (entry_q == `DMCP_SPI_ENTRY_PULSES);
  assign i2c_en = ~spi_mode & ~lk_sync_q[2];

  always_comb begin
    lk_meta_d = {standalone_select_pin, address_strap_high, address_strap_low};
    lk_sync_d = lk_meta_q;
    start_seen_d = start_tgl_q;
    stop_seen_d = stop_tgl_q;
    wr_tgl_d = wr_tgl_q ^ reg_we;
    entry_d = entry_q;
    if (!s_in_txn_q && !spi_latch_select && !lk_sync_q[2] && !spi_mode) begin
      entry_d = entry_q + 2'h1;
    end
  end

  // Entry count is cleared only by the power-on reset
  always_ff @(posedge control_serial_clock or posedge rst) begin
    if (rst) begin
      lk_meta_q <= 3'h0;
      lk_sync_q <= 3'h0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      entry_q <= 2'h0;
    end else begin
      lk_meta_q <= lk_meta_d;
      lk_sync_q <= lk_sync_d;
      start_seen_q <= start_seen_d;
      stop_seen_q <= stop_seen_d;
      wr_tgl_q <= wr_tgl_d;
      entry_q <= entry_d;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] regs_q [0:`DMCP_REG_COUNT-1];
  logic [7:0] regs_d [0:`DMCP_REG_COUNT-1];
  logic [7:0] reg_wa;
  logic [7:0] reg_wd;
  logic [7:0] i_rd;
  logic [7:0] s_rd;
  logic [7:0] iptr_q;
  logic [7:0] s_ptr_q;
  logic i_we;
  logic [7:0] i_wa;
  logic [7:0] i_wd;
  logic s_we;
  logic [7:0] s_wa;
  logic [7:0] s_wd;

  assign reg_we = i_we | s_we;
  assign reg_wa = spi_mode ? s_wa : i_wa;
  assign reg_wd = spi_mode ? s_wd : i_wd;
  // Addresses past the map read as zero and ignore writes
  assign i_rd = (iptr_q <= `DMCP_REG_LAST) ? regs_q[iptr_q[4:0]] : 8'h00;
  assign s_rd = (s_ptr_q <= `DMCP_REG_LAST) ? regs_q[s_ptr_q[4:0]] : 8'h00;

  for (genvar g = 0; g < `DMCP_REG_COUNT; g++) begin : g_reg
    always_comb begin
      regs_d[g] = (reg_we && reg_wa == 8'(g)) ? reg_wd : regs_q[g];
    end

    always_ff @(posedge control_serial_clock or posedge rst) begin
      if (rst) begin
        regs_q[g] <= REG_RESET[g*8 +: 8];
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  // ----------------------------------------
  // I2C slave engine
  // ----------------------------------------
  dmcp_pkg::dmcp_i2c_state_t ist_q;
  dmcp_pkg::dmcp_i2c_state_t ist_d;
  logic [2:0] icnt_q;
  logic [2:0] icnt_d;
  logic [6:0] ish_q;
  logic [6:0] ish_d;
  logic [7:0] irsh_q;
  logic [7:0] irsh_d;
  logic [7:0] iptr_d;
  logic irw_q;
  logic irw_d;
  logic i2c_oe_q;
  logic i2c_oe_d;
  logic [7:0] ibyte;

  always_comb begin
    ist_d = ist_q;
    icnt_d = icnt_q;
    ish_d = ish_q;
    irsh_d = irsh_q;
    iptr_d = iptr_q;
    irw_d = irw_q;
    i_we = 1'b0;
    i_wa = iptr_q;
    i_wd = {ish_q, sda_in};
    ibyte = {ish_q, sda_in};
    if (!i2c_en) begin
      ist_d = dmcp_pkg::i2c_idle;
    end else if (start_evt) begin
      ist_d = dmcp_pkg::i2c_dev;
      icnt_d = 3'h1;
      ish_d = {6'h00, sda_in};
    end else if (stop_evt) begin
      ist_d = dmcp_pkg::i2c_idle;
    end else begin
      case (ist_q)
        dmcp_pkg::i2c_dev, dmcp_pkg::i2c_reg, dmcp_pkg::i2c_wdata: begin
          ish_d = ibyte[6:0];
          icnt_d = icnt_q + 3'h1;
          if (icnt_q == `DMCP_LAST_BIT) begin
            if (ist_q == dmcp_pkg::i2c_dev) begin
              irw_d = ibyte[0];
              if (ibyte[7:1] == {lk_sync_q[1], lk_sync_q[0], `DMCP_DEV_ADDR_LOW}) begin
                ist_d = dmcp_pkg::i2c_dev_ack;
              end else begin
                ist_d = dmcp_pkg::i2c_idle;
              end
            end else if (ist_q == dmcp_pkg::i2c_reg) begin
              iptr_d = ibyte;
              ist_d = dmcp_pkg::i2c_reg_ack;
            end else begin
              i_we = 1'b1;
              iptr_d = iptr_q + 8'h01;
              ist_d = dmcp_pkg::i2c_wack;
            end
          end
        end
        dmcp_pkg::i2c_dev_ack: begin
          if (irw_q) begin
            irsh_d = i_rd;
            ist_d = dmcp_pkg::i2c_rdata;
          end else begin
            ist_d = dmcp_pkg::i2c_reg;
          end
        end
        dmcp_pkg::i2c_reg_ack, dmcp_pkg::i2c_wack: begin
          ist_d = dmcp_pkg::i2c_wdata;
        end
        dmcp_pkg::i2c_rdata: begin
          irsh_d = {irsh_q[6:0], 1'b0};
          icnt_d = icnt_q + 3'h1;
          if (icnt_q == `DMCP_LAST_BIT) begin
            iptr_d = iptr_q + 8'h01;
            ist_d = dmcp_pkg::i2c_rack;
          end
        end
        dmcp_pkg::i2c_rack: begin
          if (!sda_in) begin
            irsh_d = i_rd;
            ist_d = dmcp_pkg::i2c_rdata;
          end else begin
            ist_d = dmcp_pkg::i2c_idle;
          end
        end
        default: begin
          ist_d = dmcp_pkg::i2c_idle;
        end
      endcase
    end
  end

  always_ff @(posedge control_serial_clock or posedge rst) begin
    if (rst) begin
      ist_q <= dmcp_pkg::i2c_idle;
      icnt_q <= 3'h0;
      ish_q <= 7'h00;
      irsh_q <= 8'h00;
      iptr_q <= 8'h00;
      irw_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      icnt_q <= icnt_d;
      ish_q <= ish_d;
      irsh_q <= irsh_d;
      iptr_q <= iptr_d;
      irw_q <= irw_d;
    end
  end

  // SDA only changes while the clock is low, so it never fakes a start or stop
  always_comb begin
    i2c_oe_d = (ist_q == dmcp_pkg::i2c_dev_ack) || (ist_q == dmcp_pkg::i2c_reg_ack) ||
      (ist_q == dmcp_pkg::i2c_wack) || ((ist_q == dmcp_pkg::i2c_rdata) && !irsh_q[7]);
  end

  always_ff @(negedge control_serial_clock or posedge rst) begin
    if (rst) begin
      i2c_oe_q <= 1'b0;
    end else begin
      i2c_oe_q <= i2c_oe_d;
    end
  end

  // ----------------------------------------
  // SPI slave engine, cleared while latch is high
  // ----------------------------------------
  logic s_in_txn_d;
  logic s_live_q;
  logic s_live_d;
  logic live_now;
  logic [2:0] s_cnt_q;
  logic [2:0] s_cnt_d;
  logic [1:0] s_bidx_q;
  logic [1:0] s_bidx_d;
  logic [6:0] s_sh_q;
  logic [6:0] s_sh_d;
  logic s_rw_q;
  logic s_rw_d;
  logic s_bad_q;
  logic s_bad_d;
  logic [7:0] s_ptr_d;
  logic [7:0] s_rsh_q;
  logic [7:0] s_rsh_d;
  logic [7:0] sbyte;
  logic control_data_out_q;
  logic control_data_out_d;
  logic control_data_out_oe_q;
  logic control_data_out_oe_d;

  assign live_now = s_in_txn_q ? s_live_q : spi_mode;

  always_comb begin
    s_in_txn_d = 1'b1;
    s_live_d = live_now;
    s_cnt_d = s_cnt_q;
    s_bidx_d = s_bidx_q;
    s_sh_d = s_sh_q;
    s_rw_d = s_rw_q;
    s_bad_d = s_bad_q;
    s_ptr_d = s_ptr_q;
    s_rsh_d = s_rsh_q;
    s_we = 1'b0;
    s_wa = s_ptr_q;
    sbyte = {s_sh_q, control_data_in};
    s_wd = sbyte;
    if (live_now) begin
      s_sh_d = sbyte[6:0];
      s_cnt_d = s_cnt_q + 3'h1;
      if (s_cnt_q == `DMCP_LAST_BIT) begin
        s_bidx_d = (s_bidx_q == 2'h3) ? 2'h3 : s_bidx_q + 2'h1;
        case (s_bidx_q)
          2'h0: begin
            s_rw_d = sbyte[0];
            s_bad_d = |sbyte[7:1];
          end
          2'h1: begin
            s_ptr_d = sbyte;
          end
          default: begin
            if (s_rw_q) begin
              s_rsh_d = s_rd;
            end else begin
              s_we = !s_bad_q;
            end
            s_ptr_d = s_ptr_q + 8'h01;
          end
        endcase
      end
    end
  end

  always_ff @(posedge control_serial_clock or posedge spi_clr) begin
    if (spi_clr) begin
      s_in_txn_q <= 1'b0;
      s_live_q <= 1'b0;
      s_cnt_q <= 3'h0;
      s_bidx_q <= 2'h0;
      s_sh_q <= 7'h00;
      s_rw_q <= 1'b0;
      s_bad_q <= 1'b0;
      s_ptr_q <= 8'h00;
      s_rsh_q <= 8'h00;
    end else begin
      s_in_txn_q <= s_in_txn_d;
      s_live_q <= s_live_d;
      s_cnt_q <= s_cnt_d;
      s_bidx_q <= s_bidx_d;
      s_sh_q <= s_sh_d;
      s_rw_q <= s_rw_d;
      s_bad_q <= s_bad_d;
      s_ptr_q <= s_ptr_d;
      s_rsh_q <= s_rsh_d;
    end
  end

  always_comb begin
    control_data_out_oe_d = s_live_q && s_rw_q && !s_bad_q && (s_bidx_q == `DMCP_SPI_READ_OUT_BYTE);
    control_data_out_d = s_rsh_q[3'h7 - s_cnt_q];
  end

  always_ff @(negedge control_serial_clock or posedge spi_clr) begin
    if (spi_clr) begin
      control_data_out_q <= 1'b0;
      control_data_out_oe_q <= 1'b0;
    end else begin
      control_data_out_q <= control_data_out_d;
      control_data_out_oe_q <= control_data_out_oe_d;
    end
  end

  assign sda_out = spi_mode & control_data_out_q;
  assign sda_oe = spi_mode ? control_data_out_oe_q : i2c_oe_q;

  // ----------------------------------------
  // Crossings into the system domain
  // ----------------------------------------
  logic [1:0] x_meta_q;
  logic [1:0] x_meta_d;
  logic [1:0] x_sync_q;
  logic [1:0] x_sync_d;
  logic wr_prev_q;
  logic wr_prev_d;
  logic pulse_q;
  logic pulse_d;

  always_comb begin
    x_meta_d = {wr_tgl_q, spi_mode};
    x_sync_d = x_meta_q;
    wr_prev_d = x_sync_q[1];
    pulse_d = x_sync_q[1] ^ wr_prev_q;
  end

  // Writes in adjacent system cycles merge into one longer pulse; two writes within one cycle cancel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      x_meta_q <= 2'h0;
      x_sync_q <= 2'h0;
      wr_prev_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      x_meta_q <= x_meta_d;
      x_sync_q <= x_sync_d;
      wr_prev_q <= wr_prev_d;
      pulse_q <= pulse_d;
    end
  end

  assign spi_mode_active = x_sync_q[0];
  assign reg_update_pulse = pulse_q;

endmodule : dmcp_port

`default_nettype wire

// File: hdl/dmcp_cfg.svh
// Constants for the dual-mode control port
`ifndef DMCP_CFG_SVH
`define DMCP_CFG_SVH

`define DMCP_REG_COUNT 27
`define DMCP_REG_LAST 8'h1A
`define DMCP_DEV_ADDR_LOW 5'h11
`define DMCP_SPI_ENTRY_PULSES 2'h3
`define DMCP_SPI_FIRST_DATA_BYTE 2'h2
`define DMCP_SPI_READ_OUT_BYTE 2'h3
`define DMCP_LAST_BIT 3'h7
`define DMCP_REG_RESET {216'h000000000020000000000FFF02A0A0A0A0F0321000023F00004100}

`endif

// File: hdl/dmcp_pkg.sv
// Types shared by the dual-mode control port
package dmcp_pkg;

  typedef logic [7:0] dmcp_byte_t;

  typedef enum logic [8:0] {
    i2c_idle    = 9'h001,
    i2c_dev     = 9'h002,
    i2c_dev_ack = 9'h004,
    i2c_reg     = 9'h008,
    i2c_reg_ack = 9'h010,
    i2c_wdata   = 9'h020,
    i2c_wack    = 9'h040,
    i2c_rdata   = 9'h080,
    i2c_rack    = 9'h100
  } dmcp_i2c_state_t;

endpackage : dmcp_pkg

// File: hdl/dmcp_sa_if.sv
// Standalone strap settings passed from the strap decoder to the port top
`timescale 1ns/100ps
`default_nettype none

interface dmcp_sa_if;
  logic active;
  logic tdm;
  logic eight_slot;
  logic port_slave;
  logic mclk_384;
  logic rate_96k;
  modport src (output active, output tdm, output eight_slot, output port_slave,
    output mclk_384, output rate_96k);
  modport dst (input active, input tdm, input eight_slot, input port_slave,
    input mclk_384, input rate_96k);
endinterface : dmcp_sa_if

`default_nettype wire

// File: hdl/dmcp_standalone.sv
// Standalone strap sampling and decode in the system clock domain
`timescale 1ns/100ps
`default_nettype none

module dmcp_standalone (
  input wire logic clock,
  input wire logic rst,
  input wire logic standalone_select_pin,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic sda_level,
  input wire logic scl_level,
  input wire logic serial_output_two,
  dmcp_sa_if.src sa
);

  // ----------------------------------------
  // Strap synchronisers and decode
  // ----------------------------------------
  logic [5:0] meta_q;
  logic [5:0] meta_d;
  logic [5:0] sync_q;
  logic [5:0] sync_d;
  logic [5:0] cfg_q;
  logic [5:0] cfg_d;
  logic act;

  always_comb begin
    meta_d = {serial_output_two, scl_level, sda_level, address_strap_high,
      address_strap_low, standalone_select_pin};
    sync_d = meta_q;
    act = sync_q[0];
    cfg_d[0] = act;
    cfg_d[1] = act & sync_q[1];
    cfg_d[2] = act & sync_q[1] & sync_q[5];
    cfg_d[3] = act & sync_q[2];
    cfg_d[4] = act & sync_q[3];
    cfg_d[5] = act & sync_q[4];
  end

  // Straps are sampled continuously, so a late strap settles in three cycles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
      cfg_q <= 6'h00;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      cfg_q <= cfg_d;
    end
  end

  assign sa.active = cfg_q[0];
  assign sa.tdm = cfg_q[1];
  assign sa.eight_slot = cfg_q[2];
  assign sa.port_slave = cfg_q[3];
  assign sa.mclk_384 = cfg_q[4];
  assign sa.rate_96k = cfg_q[5];

endmodule : dmcp_standalone

`default_nettype wire

// File: sim/dmcp_port_asserts.sv
// Concurrent checks on the control port status outputs
`timescale 1ns/100ps
`default_nettype none

module dmcp_port_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic standalone_select_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic standalone_active,
  input wire logic boost_power_down,
  input wire logic mic_bias_power_down,
  input wire logic diagnostics_power_down,
  input wire logic port_format_tdm,
  input wire logic tdm_eight_slot,
  input wire logic port_is_slave,
  input wire logic mclk_ratio_384,
  input wire logic sample_rate_96k,
  input wire logic spi_mode_active,
  input wire logic reg_update_pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Straps are decoded three edges late
  // ----------------------------------------
  a_sa_power_down:
    assert property ($stable(standalone_select_pin) [*4] |->
      {boost_power_down, mic_bias_power_down, diagnostics_power_down}
      == {3{standalone_select_pin}}) else $error("power downs differ from standalone pin");
  a_sa_select:
    assert property ($stable(standalone_select_pin) [*4] |->
      standalone_active == standalone_select_pin) else $error("standalone state wrong");
  a_tdm_strap:
    assert property ((standalone_select_pin && $stable(address_strap_low)) [*4] |->
      port_format_tdm == address_strap_low) else $error("port format wrong");
  a_slave_strap:
    assert property ((standalone_select_pin && $stable(address_strap_high)) [*4] |->
      port_is_slave == address_strap_high) else $error("port direction wrong");
  a_eight_slot:
    assert property (tdm_eight_slot |-> port_format_tdm) else $error("eight slot without tdm");
  a_sa_off_quiet:
    assert property (!standalone_active |-> !(port_format_tdm || tdm_eight_slot ||
      port_is_slave || mclk_ratio_384 || sample_rate_96k)) else $error("strap output set");

  // ----------------------------------------
  // Control link
  // ----------------------------------------
  a_spi_sticky:
    assert property (spi_mode_active |=> spi_mode_active) else $error("left spi mode");
  a_control_data_out_release:
    assert property (spi_mode_active && address_strap_low |-> !sda_oe)
    else $error("data out driven while deselected");
  a_i2c_drain:
    assert property (!spi_mode_active && sda_oe |-> !sda_out) else $error("sda driven high");
  a_update_pulse:
    assert property (reg_update_pulse |=> !reg_update_pulse) else $error("update pulse long");
endmodule : dmcp_port_asserts

bind dmcp_port dmcp_port_asserts dmcp_port_asserts_i (.clock, .rst, .address_strap_low,
  .address_strap_high, .standalone_select_pin, .sda_out, .sda_oe, .standalone_active,
  .boost_power_down, .mic_bias_power_down, .diagnostics_power_down, .port_format_tdm,
  .tdm_eight_slot, .port_is_slave, .mclk_ratio_384, .sample_rate_96k, .spi_mode_active,
  .reg_update_pulse);

`default_nettype wire

// File: sim/dmcp_host_model.sv
// Host controller model driving the shared I2C and SPI control pins
`timescale 1ns/100ps
`default_nettype none

module dmcp_host_model (
  output logic control_serial_clock,
  output logic sda_pull_low,
  output logic spi_latch_select_n,
  output logic control_data_in,
  input wire logic sda_line,
  input wire logic sda_oe
);
  // Clock rests high between frames, where the pull-up leaves it
  initial begin
    control_serial_clock = 1'h1;
    sda_pull_low = 1'h0;
    spi_latch_select_n = 1'h1;
    control_data_in = 1'h1;
  end

  // ----------------------------------------
  // I2C and SPI master, 15 ns bit period
  // ----------------------------------------
  task automatic i2c_bit(input logic b, input logic b_late, output logic r);
    sda_pull_low = ~b;
    #3.75;
    control_serial_clock = 1'h1;
    #3.75;
    r = sda_line;
    sda_pull_low = ~b_late;
    #3.75;
    control_serial_clock = 1'h0;
    #3.75;
  endtask : i2c_bit

  task automatic i2c_start;
    logic r;
    i2c_bit(1'h1, 1'h0, r);
  endtask : i2c_start

  task automatic i2c_stop;
    sda_pull_low = 1'h1;
    #3.75;
    control_serial_clock = 1'h1;
    #3.75;
    sda_pull_low = 1'h0;
    #7.5;
  endtask : i2c_stop

  task automatic i2c_byte(input dmcp_pkg::dmcp_byte_t tx, input logic ack_in,
      output dmcp_pkg::dmcp_byte_t rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(tx[i], tx[i], rx[i]);
    end
    i2c_bit(ack_in, ack_in, ack);
  endtask : i2c_byte

  task automatic spi_xfer(input dmcp_pkg::dmcp_byte_t tx[$],
      output dmcp_pkg::dmcp_byte_t rx[$], output logic [7:0] oe_first);
    dmcp_pkg::dmcp_byte_t b;
    rx = {};
    oe_first = 8'h00;
    spi_latch_select_n = 1'h0;
    #7.5;
    foreach (tx[k]) begin
      for (int i = 7; i >= 0; i--) begin
        control_serial_clock = 1'h0;
        control_data_in = tx[k][i];
        #7.5;
        control_serial_clock = 1'h1;
        b[i] = sda_line;
        oe_first[k] = (i == 7) ? sda_oe : oe_first[k];
        #7.5;
      end
      rx.push_back(b);
    end
    spi_latch_select_n = 1'h1;
    control_data_in = 1'h1;
    #15;
  endtask : spi_xfer
endmodule : dmcp_host_model

`default_nettype wire

// File: sim/test_dual_mode_control_port.sv
// Self-checking bench for the dual-mode control port
`timescale 1ns/100ps
`default_nettype none
`include "dmcp_cfg.svh"

module test_dual_mode_control_port;
  localparam dmcp_pkg::dmcp_byte_t wr_addr = {2'h3, `DMCP_DEV_ADDR_LOW, 1'h0};
  localparam dmcp_pkg::dmcp_byte_t rd_addr = {2'h3, `DMCP_DEV_ADDR_LOW, 1'h1};
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic sa_sel = 1'h1;
  logic [4:0] st = 5'h00;
  logic lclk, pull_low, latch_n, din, sda_line, sda_in, control_serial_clock;
  logic address_strap_low, address_strap_high, standalone_select_pin, serial_output_two;
  logic sda_out, sda_oe, standalone_active, boost_power_down, mic_bias_power_down;
  logic diagnostics_power_down, port_format_tdm, tdm_eight_slot, port_is_slave;
  logic mclk_ratio_384, sample_rate_96k, spi_mode_active, reg_update_pulse;
  logic [8:0] sa_seen;
  int error_cnt = 0;
  int total_checks = 0;
  int upd_cnt = 0;

  always #25 clock = ~clock;

  // Count pulses away from the edge that launches them
  always @(negedge clock) begin
    if (reg_update_pulse) begin
      upd_cnt++;
    end
  end

  // ----------------------------------------
  // Pins shared by straps and the host
  // ----------------------------------------
  assign control_serial_clock = sa_sel ? st[2] : lclk;
  assign address_strap_low = sa_sel ? st[0] : latch_n;
  assign address_strap_high = sa_sel ? st[1] : din;
  assign sda_in = sa_sel ? st[3] : sda_line;
  assign serial_output_two = st[4];
  assign standalone_select_pin = sa_sel;
  // Pull-up keeps a released line high
  assign sda_line = sda_oe ? (sda_out & ~pull_low) : ~pull_low;
  assign sa_seen = {standalone_active, boost_power_down, mic_bias_power_down,
    diagnostics_power_down, port_format_tdm, tdm_eight_slot, port_is_slave,
    mclk_ratio_384, sample_rate_96k};

  dmcp_port dmcp_port_i (.clock, .rst, .control_serial_clock, .sda_in, .sda_out, .sda_oe,
    .address_strap_low, .address_strap_high, .standalone_select_pin, .serial_output_two,
    .standalone_active, .boost_power_down, .mic_bias_power_down, .diagnostics_power_down,
    .port_format_tdm, .tdm_eight_slot, .port_is_slave, .mclk_ratio_384, .sample_rate_96k,
    .spi_mode_active, .reg_update_pulse);

  dmcp_host_model dmcp_host_model_i (.control_serial_clock(lclk), .sda_pull_low(pull_low),
    .spi_latch_select_n(latch_n), .control_data_in(din), .sda_line, .sda_oe);

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  function automatic logic [8:0] sa_exp(input logic on, input logic [4:0] s);
    return {{4{on}}, on & s[0], on & s[0] & s[4], on & s[1], on & s[3], on & s[2]};
  endfunction : sa_exp

  task automatic settle;
    repeat (5) @(posedge clock);
    #2;
  endtask : settle

  task automatic i2c_send(input dmcp_pkg::dmcp_byte_t b, input logic exp_ack);
    dmcp_pkg::dmcp_byte_t rx;
    logic ack;
    dmcp_host_model_i.i2c_byte(b, 1'h1, rx, ack);
    check("i2c ack", 24'(ack), 24'(exp_ack));
  endtask : i2c_send

  task automatic i2c_recv(input dmcp_pkg::dmcp_byte_t exp, input logic more);
    dmcp_pkg::dmcp_byte_t rx;
    logic ack;
    dmcp_host_model_i.i2c_byte(8'hFF, ~more, rx, ack);
    check("i2c read data", 24'(rx), 24'(exp));
  endtask : i2c_recv

  task automatic i2c_read2(input dmcp_pkg::dmcp_byte_t ra, input dmcp_pkg::dmcp_byte_t e0,
      input dmcp_pkg::dmcp_byte_t e1);
    dmcp_host_model_i.i2c_start();
    i2c_send(wr_addr, 1'h0);
    i2c_send(ra, 1'h0);
    dmcp_host_model_i.i2c_start();
    i2c_send(rd_addr, 1'h0);
    i2c_recv(e0, 1'h1);
    i2c_recv(e1, 1'h0);
    dmcp_host_model_i.i2c_stop();
  endtask : i2c_read2

  // Whole run takes about ten microseconds
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    dmcp_pkg::dmcp_byte_t a, b, d0, d1, e0, e1, e2;
    dmcp_pkg::dmcp_byte_t tx[$], rx[$];
    logic [7:0] oe;
    void'($urandom(32'h90E7));
    repeat (5) @(posedge clock);
    #2 rst = 1'h0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clock);
      #2 st = (n == 0) ? 5'h1F : (n == 1) ? 5'h00 : 5'($urandom);
      settle();
      check("standalone", 24'(sa_seen), 24'(sa_exp(1'h1, st)));
    end
    sa_sel = 1'h0;
    rst = 1'h1;
    settle();
    rst = 1'h0;
    settle();
    check("standalone off", 24'(sa_seen), 24'(sa_exp(1'h0, st)));
    a = 8'($urandom_range(24));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    dmcp_host_model_i.i2c_start();
    i2c_send(wr_addr ^ 8'h04, 1'h1);
    dmcp_host_model_i.i2c_stop();
    dmcp_host_model_i.i2c_start();
    i2c_send(wr_addr, 1'h0);
    i2c_send(a, 1'h0);
    i2c_send(d0, 1'h0);
    i2c_send(d1, 1'h0);
    dmcp_host_model_i.i2c_stop();
    settle();
    check("update pulses", 24'(upd_cnt), 24'h2);
    i2c_read2(a, d0, d1);
    // Stop in mid data byte must drop that byte
    dmcp_host_model_i.i2c_start();
    i2c_send(wr_addr, 1'h0);
    i2c_send(a, 1'h0);
    repeat (4) dmcp_host_model_i.i2c_bit(~d0[0], ~d0[0], oe[0]);
    dmcp_host_model_i.i2c_stop();
    i2c_read2(a, d0, d1);
    tx = {8'h00, a, ~d0};
    repeat (3) begin
      check("spi mode", 24'(spi_mode_active), 24'h0);
      dmcp_host_model_i.spi_xfer(tx, rx, oe);
      settle();
    end
    check("spi mode", 24'(spi_mode_active), 24'h1);
    // Burst must miss register a, which the last read expects intact
    b = 8'((a + 32'h1 + $urandom_range(32'h15)) % 32'h19);
    e0 = 8'hFF;
    e1 = 8'h00;
    e2 = 8'($urandom);
    tx = {8'h00, b, e0, e1, e2};
    dmcp_host_model_i.spi_xfer(tx, rx, oe);
    check("spi write drive", 24'(oe), 24'h0);
    tx = {8'h02, b, ~e0};
    dmcp_host_model_i.spi_xfer(tx, rx, oe);
    dmcp_host_model_i.i2c_start();
    i2c_send(wr_addr, 1'h1);
    dmcp_host_model_i.i2c_stop();
    settle();
    check("spi mode", 24'(spi_mode_active), 24'h1);
    check("update pulses", 24'(upd_cnt), 24'h5);
    tx = {8'h01, b, 8'h00, 8'h00, 8'h00, 8'h00};
    dmcp_host_model_i.spi_xfer(tx, rx, oe);
    check("spi read drive", 24'(oe[5:0]), 24'h38);
    check("spi burst", {rx[3], rx[4], rx[5]}, {e0, e1, e2});
    tx = {8'h01, a, 8'h00, 8'h00};
    dmcp_host_model_i.spi_xfer(tx, rx, oe);
    check("spi read", 24'(rx[3]), 24'(d0));
    settle();
    final_report();
  end
endmodule : test_dual_mode_control_port

`default_nettype wire
